// ===== hdl/sdr_host_end.sv
/*
 * Controller end: power-up sequence, mode programming, per-bank
 * open-row tracking and single-word read/write requests.
 * Assumes a DRAM end on the other side of sdr_if and one clock.
 */
// Function
// - row on twelve lines, column on nine
// - bank select picks bank for activate, access
// - chip select high ignores new commands
// - three strobes sampled together decode command
// - read byte mask floats output two later
// - write byte mask blocks byte immediately
// - clock enable low freezes internal clock
// - mode register undefined until programmed; model resets it to 12'h000
// - pause with no-op, clock enable, masks high
// - precharge all banks before mode set
// - eight auto refreshes during initialization
// - mode set needs precharged banks, enable high
// - all strobes low set the mode
// - wait mode-set cycle time afterwards
// - activate first, then wait activate-to-column delay
// - precharge before reactivate, row cycle spacing
// - space activates across banks bank-to-bank delay
// - close rows before row active time expires
// - column strobe low, write strobe picks direction
// - other row needs precharge then activate
// - column commands accepted every clock
// - mode selects burst type and length
// - precharge closes one bank or all
`timescale 1ns/100ps
`include "sdr_params.svh"
module sdr_host_end (
    input logic clk,
    input logic rstn,
    sdr_if.ctrl bus,
    input logic req_valid,
    output logic req_ready,
    input logic req_write,
    input logic [1:0] req_bank,
    input logic [`SDR_ROW_W-1:0] req_row,
    input logic [`SDR_COL_W-1:0] req_col,
    input logic [`SDR_DQ_W-1:0] req_wdata,
    input logic [1:0] req_wmask,
    input logic sleep,
    output logic rsp_valid,
    output logic [`SDR_DQ_W-1:0] rsp_data,
    output logic init_done
);
    import sdr_pkg::*;
    sdr_host_st_t state;
    sdr_host_st_t next_state;
    logic [`SDR_WAIT_W-1:0] wait_cnt;
    logic [`SDR_WAIT_W-1:0] next_wait;
    logic [3:0] ref_left;
    logic pend;
    logic p_write;
    logic [1:0] p_bank;
    logic [`SDR_ROW_W-1:0] p_row;
    logic [`SDR_COL_W-1:0] p_col;
    logic [`SDR_DQ_W-1:0] p_wdata;
    logic [1:0] p_wmask;
    logic [`SDR_BANKS-1:0] open;
    logic [`SDR_ROW_W-1:0] row [`SDR_BANKS];
    logic [`SDR_AGE_W-1:0] age [`SDR_BANKS];
    logic [`SDR_WAIT_W-1:0] rrd_cnt;
    logic [`SDR_HOST_CL:0] rd_sh;
    sdr_cmd_t next_cmd;
    logic [1:0] next_bank;
    logic [`SDR_ADDR_W-1:0] next_addr;
    logic do_act;
    logic do_pre;
    logic do_col;
    logic do_ref;
    logic exp_hit;
    logic [1:0] exp_bank;
    logic want_sleep;
    logic accept;
    assign accept = req_valid && req_ready;
    assign want_sleep = sleep && !pend && !exp_hit;
    // first open bank close to its row active limit
    always_comb begin
        exp_hit = 1'b0;
        exp_bank = 2'h0;
        for (int i = 0; i < `SDR_BANKS; i++) begin
            if (!exp_hit && open[i] && age[i] >= `SDR_AGE_W'(
                    `SDR_ROW_ACTIVE_MAX_CYC - `SDR_ROW_ACTIVE_GUARD)) begin
                exp_hit = 1'b1;
                exp_bank = 2'(i);
            end
        end
    end
    always_comb begin
        next_state = state;
        next_cmd = no_operation_cmd;
        next_bank = 2'h0;
        next_addr = '0;
        next_wait = '0;
        do_act = 1'b0;
        do_pre = 1'b0;
        do_col = 1'b0;
        do_ref = 1'b0;
        if (wait_cnt == '0) begin
            case (state)
                hst_pause: begin
                    next_cmd = cmd_precharge;
                    next_addr[`SDR_AP_BIT] = 1'b1;
                    do_pre = 1'b1;
                    next_wait = `SDR_WAIT_W'(`SDR_PRECHARGE_CYC - 1);
                    next_state = hst_refresh;
                end
                hst_refresh: begin
                    if (ref_left != 4'h0) begin
                        next_cmd = cmd_auto_refresh;
                        do_ref = 1'b1;
                        next_wait = `SDR_WAIT_W'(`SDR_ROW_CYCLE_CYC - 1);
                    end else begin
                        next_state = hst_mode_set;
                    end
                end
                hst_mode_set: begin
                    // banks closed and enable high since reset
                    next_cmd = cmd_mode_set;
                    next_addr = `SDR_MODE_VALUE;
                    next_wait = `SDR_WAIT_W'(`SDR_MODE_SET_CYC - 1);
                    next_state = hst_idle;
                end
                hst_idle: begin
                    if (!bus.cke || want_sleep) begin
                        next_cmd = no_operation_cmd;
                    end else if (exp_hit) begin
                        next_cmd = cmd_precharge;
                        next_bank = exp_bank;
                        do_pre = 1'b1;
                        next_wait = `SDR_WAIT_W'(`SDR_PRECHARGE_CYC - 1);
                    end else if (pend && open[p_bank]) begin
                        next_bank = p_bank;
                        if (row[p_bank] == p_row) begin
                            next_cmd = p_write ? cmd_write : cmd_read;
                            next_addr[`SDR_COL_W-1:0] = p_col;
                            do_col = 1'b1;
                        end else begin
                            next_cmd = cmd_precharge;
                            do_pre = 1'b1;
                            next_wait = `SDR_WAIT_W'(`SDR_PRECHARGE_CYC - 1);
                        end
                    end else if (pend && rrd_cnt == '0 &&
                            age[p_bank] >= `SDR_AGE_W'(
                            `SDR_ROW_CYCLE_CYC - 1)) begin
                        next_cmd = cmd_activate;
                        next_bank = p_bank;
                        next_addr = p_row;
                        do_act = 1'b1;
                        next_wait = `SDR_WAIT_W'(
                            `SDR_ACTIVATE_TO_COLUMN_CYC - 1);
                    end
                end
                default: next_state = hst_pause;
            endcase
        end
    end
    // command pins, all from flops; masks stay high until idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= hst_pause;
            wait_cnt <= `SDR_WAIT_W'(`SDR_INIT_PAUSE_CYC - 1);
            bus.cs_n <= 1'b1;
            bus.ras_n <= 1'b1;
            bus.cas_n <= 1'b1;
            bus.we_n <= 1'b1;
            bus.cke <= 1'b1;
            bus.bank_select <= 2'h0;
            bus.addr <= '0;
            bus.upper_lower_byte_mask <= 2'h3;
            bus.host_dq <= '0;
            bus.host_dq_oe <= 1'b0;
        end else begin
            state <= next_state;
            wait_cnt <= (wait_cnt != '0) ? wait_cnt - 1'b1 : next_wait;
            {bus.ras_n, bus.cas_n, bus.we_n} <= next_cmd;
            bus.cs_n <= (next_cmd == no_operation_cmd);
            bus.bank_select <= next_bank;
            bus.addr <= next_addr;
            bus.cke <= !(state == hst_idle && want_sleep);
            if (state != hst_idle) begin
                bus.upper_lower_byte_mask <= 2'h3;
            end else begin
                bus.upper_lower_byte_mask <= do_col ? p_wmask : 2'h0;
            end
            bus.host_dq <= p_wdata;
            bus.host_dq_oe <= do_col && p_write;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_left <= 4'(`SDR_INIT_REFRESHES);
            init_done <= 1'b0;
        end else begin
            ref_left <= ref_left - 4'(do_ref);
            init_done <= (state == hst_idle);
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend <= 1'b0;
            req_ready <= 1'b0;
            p_write <= 1'b0;
            p_bank <= 2'h0;
            p_row <= '0;
            p_col <= '0;
            p_wdata <= '0;
            p_wmask <= 2'h0;
        end else if (accept) begin
            pend <= 1'b1;
            req_ready <= 1'b0;
            p_write <= req_write;
            p_bank <= req_bank;
            p_row <= req_row;
            p_col <= req_col;
            p_wdata <= req_wdata;
            p_wmask <= req_wmask;
        end else begin
            if (do_col) begin
                pend <= 1'b0;
            end
            req_ready <= (state == hst_idle) && !pend;
        end
    end
    // per-bank open state, row and age since activate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            open <= '0;
            rrd_cnt <= '0;
            for (int i = 0; i < `SDR_BANKS; i++) begin
                row[i] <= '0;
                age[i] <= `SDR_AGE_MAX;
            end
        end else begin
            for (int i = 0; i < `SDR_BANKS; i++) begin
                if (age[i] != `SDR_AGE_MAX) begin
                    age[i] <= age[i] + 1'b1;
                end
            end
            rrd_cnt <= rrd_cnt - `SDR_WAIT_W'(rrd_cnt != '0);
            if (do_act) begin
                open[next_bank] <= 1'b1;
                row[next_bank] <= p_row;
                age[next_bank] <= '0;
                rrd_cnt <= `SDR_WAIT_W'(`SDR_BANK_TO_BANK_CYC - 1);
            end else if (do_pre) begin
                if (next_addr[`SDR_AP_BIT]) begin
                    open <= '0;
                end else begin
                    open[next_bank] <= 1'b0;
                end
            end
        end
    end
    // read data returns the latency after the command on the pins
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_sh <= '0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end else begin
            rd_sh <= {rd_sh[`SDR_HOST_CL-1:0], do_col && !p_write};
            rsp_valid <= rd_sh[`SDR_HOST_CL];
            if (rd_sh[`SDR_HOST_CL]) begin
                rsp_data <= bus.data_io;
            end
        end
    end
endmodule // sdr_host_end

// ===== hdl/sdr_mem_end.sv
/*
 * DRAM end: command decoder, bank and mode state, burst engine,
 * byte masks, clock-enable modes and a small flip-flop memory.
 * Assumes the controller keeps its own timing and ordering duties.
 */
`timescale 1ns/100ps
`include "sdr_params.svh"
module sdr_mem_end (
    input logic clk,
    input logic rstn,
    sdr_if.mem bus,
    output sdr_pkg::sdr_pwr_t power_state,
    output logic [`SDR_ADDR_W-1:0] mode_reg,
    output logic [`SDR_BANKS-1:0] bank_open
);
    import sdr_pkg::*;

    logic live;
    logic [`SDR_ROW_W-1:0] open_row [`SDR_BANKS];
    logic [`SDR_DQ_W-1:0] mem [`SDR_MEM_WORDS];
    logic burst_on;
    logic burst_wr;
    logic [1:0] burst_bank;
    logic [`SDR_COL_W-1:0] burst_col;
    logic [`SDR_COL_W-1:0] beat;
    logic [`SDR_DQ_W-1:0] pipe0;
    logic [`SDR_DQ_W-1:0] pipe1;
    logic pipe0_v;
    logic pipe1_v;
    logic [1:0] mask_q;
    sdr_cmd_t cmd;
    logic sel;
    logic col_cmd;
    logic stop;
    logic beat_on;
    logic beat_wr;
    logic [1:0] beat_bank;
    logic [`SDR_COL_W-1:0] beat_col;
    logic [`SDR_IDX_W-1:0] beat_idx;
    logic [2:0] bl;

    function automatic logic [`SDR_COL_W-1:0] burst_mask(
        input logic [2:0] len);
        case (len)
            `SDR_BL_2: burst_mask = 9'h001;
            `SDR_BL_4: burst_mask = 9'h003;
            `SDR_BL_8: burst_mask = 9'h007;
            `SDR_BL_FULL: burst_mask = 9'h1ff;
            default: burst_mask = 9'h000;
        endcase
    endfunction

    // wraps inside the burst-aligned block, no carry out of it
    function automatic logic [`SDR_COL_W-1:0] col_at(
        input logic [`SDR_COL_W-1:0] start,
        input logic [`SDR_COL_W-1:0] n,
        input logic [2:0] len,
        input logic il);
        logic [`SDR_COL_W-1:0] m;
        logic [`SDR_COL_W-1:0] step;
        m = burst_mask(len);
        step = il ? (start ^ n) : (start + n);
        col_at = (start & ~m) | (step & m);
    endfunction

    assign bl = mode_reg[`SDR_MR_BL_LSB +: 3];
    assign cmd = sdr_cmd_t'({bus.ras_n, bus.cas_n, bus.we_n});
    assign sel = live && !bus.cs_n;
    assign col_cmd = sel && (cmd == cmd_read || cmd == cmd_write);

    always_comb begin
        stop = sel && (cmd == cmd_burst_stop || (cmd == cmd_precharge &&
            (bus.addr[`SDR_AP_BIT] || bus.bank_select == burst_bank)));
        beat_on = 1'b0;
        beat_wr = burst_wr;
        beat_bank = burst_bank;
        beat_col = col_at(burst_col, beat, bl, mode_reg[`SDR_MR_BT_BIT]);
        if (col_cmd) begin
            beat_on = 1'b1;
            beat_wr = (cmd == cmd_write);
            beat_bank = bus.bank_select;
            beat_col = bus.addr[`SDR_COL_W-1:0];
        end else if (live && burst_on && !stop) begin
            beat_on = 1'b1;
        end
        beat_idx = {beat_bank, open_row[beat_bank][`SDR_IDX_ROW-1:0],
            beat_col[`SDR_IDX_COL-1:0]};
    end

    // clock enable acts one edge late, as a frozen internal clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            live <= 1'b1;
            power_state <= pwr_run;
        end else begin
            live <= bus.cke;
            if (!bus.cke) begin
                if (sel && cmd == cmd_auto_refresh) begin
                    power_state <= pwr_self_refresh;
                end else if (power_state == pwr_run) begin
                    power_state <= burst_on ? pwr_suspend : pwr_down;
                end
            end else begin
                power_state <= pwr_run;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= `SDR_MODE_RESET;
            bank_open <= '0;
            for (int i = 0; i < `SDR_BANKS; i++) begin
                open_row[i] <= '0;
            end
        end else if (sel) begin
            case (cmd)
                cmd_activate: begin
                    bank_open[bus.bank_select] <= 1'b1;
                    open_row[bus.bank_select] <= bus.addr;
                end
                cmd_precharge: begin
                    if (bus.addr[`SDR_AP_BIT]) begin
                        bank_open <= '0;
                    end else begin
                        bank_open[bus.bank_select] <= 1'b0;
                    end
                end
                cmd_mode_set: mode_reg <= bus.addr;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            burst_on <= 1'b0;
            burst_wr <= 1'b0;
            burst_bank <= 2'h0;
            burst_col <= 9'h000;
            beat <= 9'h000;
        end else if (col_cmd) begin
            burst_on <= (burst_mask(bl) != 9'h000);
            burst_wr <= (cmd == cmd_write);
            burst_bank <= bus.bank_select;
            burst_col <= bus.addr[`SDR_COL_W-1:0];
            beat <= 9'h001;
        end else if (live && burst_on) begin
            if (stop || (beat == burst_mask(bl) && bl != `SDR_BL_FULL)) begin
                burst_on <= 1'b0;
            end
            beat <= beat + 9'h001;
        end
    end

    // data storage, no reset: contents are undefined until written
    always_ff @(posedge clk) begin
        if (beat_on && beat_wr) begin
            for (int b = 0; b < 2; b++) begin
                if (!bus.upper_lower_byte_mask[b]) begin
                    mem[beat_idx][8*b +: 8] <= bus.data_io[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pipe0 <= '0;
            pipe1 <= '0;
            pipe0_v <= 1'b0;
            pipe1_v <= 1'b0;
            mask_q <= 2'h3;
            bus.dev_dq <= '0;
            bus.dev_dq_oe <= 2'h0;
        end else if (live) begin
            pipe0 <= mem[beat_idx];
            pipe0_v <= beat_on && !beat_wr;
            pipe1 <= pipe0;
            pipe1_v <= pipe0_v;
            mask_q <= bus.upper_lower_byte_mask;
            if (mode_reg[`SDR_MR_CL_LSB +: 3] == `SDR_CL_3) begin
                bus.dev_dq <= pipe1;
                bus.dev_dq_oe <= {2{pipe1_v}} & ~mask_q;
            end else begin
                bus.dev_dq <= pipe0;
                bus.dev_dq_oe <= {2{pipe0_v}} & ~mask_q;
            end
        end
    end

endmodule // sdr_mem_end

// ===== shared/sdr_if.sv
/*
 * Pin bundle between the memory controller end and the DRAM end.
 * Assumes each end drives only its own copy of the data pins; the
 * shared data wire is resolved here from the two enables.
 */
`timescale 1ns/100ps
`include "sdr_params.svh"
interface sdr_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] bank_select;
    logic [`SDR_ADDR_W-1:0] addr;
    logic [1:0] upper_lower_byte_mask;
    logic [`SDR_DQ_W-1:0] host_dq;
    logic host_dq_oe;
    logic [`SDR_DQ_W-1:0] dev_dq;
    logic [1:0] dev_dq_oe;
    logic [`SDR_DQ_W-1:0] data_io;

    // undriven lanes read as zero
    for (genvar b = 0; b < 2; b++) begin : g_lane
        assign data_io[8*b +: 8] = dev_dq_oe[b] ? dev_dq[8*b +: 8] :
            host_dq_oe ? host_dq[8*b +: 8] : 8'h00;
    end

    modport ctrl (
        output cs_n, ras_n, cas_n, we_n, cke, bank_select, addr,
        output upper_lower_byte_mask, host_dq, host_dq_oe,
        input data_io
    );
    modport mem (
        input cs_n, ras_n, cas_n, we_n, cke, bank_select, addr,
        input upper_lower_byte_mask, data_io,
        output dev_dq, dev_dq_oe
    );
endinterface

// ===== shared/sdr_params.svh
/*
 * Constants for the four-bank 16-bit synchronous DRAM command link:
 * pin widths, mode word fields, model sizes and timing counts.
 * Assumes a single 10 MHz clock shared by both ends.
 */
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH

`define SDR_ADDR_W 12
`define SDR_ROW_W 12
`define SDR_COL_W 9
`define SDR_BANKS 4
`define SDR_DQ_W 16
`define SDR_AP_BIT 10

// mode word layout
`define SDR_MR_BL_LSB 0
`define SDR_MR_BT_BIT 3
`define SDR_MR_CL_LSB 4
`define SDR_BL_1 3'h0
`define SDR_BL_2 3'h1
`define SDR_BL_4 3'h2
`define SDR_BL_8 3'h3
`define SDR_BL_FULL 3'h7
`define SDR_CL_3 3'h3
`define SDR_MODE_RESET 12'h000
// burst of one, sequential, read latency two
`define SDR_MODE_VALUE 12'h020
`define SDR_HOST_CL 2

// memory model: bank, low row bits, low column bits
`define SDR_IDX_ROW 2
`define SDR_IDX_COL 4
`define SDR_IDX_W 8
`define SDR_MEM_WORDS 256

`define SDR_CLK_NS 100
`define SDR_CEIL(ns) \
    ((((ns) + `SDR_CLK_NS - 1) / `SDR_CLK_NS) > 0 ? \
     (((ns) + `SDR_CLK_NS - 1) / `SDR_CLK_NS) : 1)
`define SDR_FLOOR(ns) \
    (((ns) / `SDR_CLK_NS) > 0 ? ((ns) / `SDR_CLK_NS) : 1)

`define SDR_INIT_PAUSE_NS 200000
`define SDR_INIT_PAUSE_CYC `SDR_CEIL(`SDR_INIT_PAUSE_NS)
`define SDR_PRECHARGE_TIME_NS 20
`define SDR_PRECHARGE_CYC `SDR_CEIL(`SDR_PRECHARGE_TIME_NS)
`define SDR_ACTIVATE_TO_COLUMN_DELAY_NS 20
`define SDR_ACTIVATE_TO_COLUMN_CYC `SDR_CEIL(`SDR_ACTIVATE_TO_COLUMN_DELAY_NS)
`define SDR_ROW_CYCLE_TIME_NS 60
`define SDR_ROW_CYCLE_CYC `SDR_CEIL(`SDR_ROW_CYCLE_TIME_NS)
`define SDR_BANK_TO_BANK_DELAY_NS 12
`define SDR_BANK_TO_BANK_CYC `SDR_CEIL(`SDR_BANK_TO_BANK_DELAY_NS)
`define SDR_MODE_SET_CYCLE_TIME_NS 20
`define SDR_MODE_SET_CYC `SDR_CEIL(`SDR_MODE_SET_CYCLE_TIME_NS)
`define SDR_ROW_ACTIVE_TIME_MAX_NS 100000
`define SDR_ROW_ACTIVE_MAX_CYC `SDR_FLOOR(`SDR_ROW_ACTIVE_TIME_MAX_NS)
`define SDR_ROW_ACTIVE_GUARD 8
`define SDR_INIT_REFRESHES 8

`define SDR_WAIT_W 12
`define SDR_AGE_W 12
`define SDR_AGE_MAX 12'hfff

`endif

// ===== shared/sdr_pkg.sv
/*
 * Types shared by both ends of the DRAM command link.
 * Assumes sdr_params.svh for all numeric constants.
 */
package sdr_pkg;

    // {row strobe, column strobe, write strobe}, all active low
    typedef enum logic [2:0] {
        cmd_mode_set = 3'h0,
        cmd_auto_refresh = 3'h1,
        cmd_precharge = 3'h2,
        cmd_activate = 3'h3,
        cmd_write = 3'h4,
        cmd_read = 3'h5,
        cmd_burst_stop = 3'h6,
        no_operation_cmd = 3'h7
    } sdr_cmd_t;

    typedef enum logic [3:0] {
        pwr_run = 4'h1,
        pwr_suspend = 4'h2,
        pwr_down = 4'h4,
        pwr_self_refresh = 4'h8
    } sdr_pwr_t;

    typedef enum logic [3:0] {
        hst_pause = 4'h1,
        hst_refresh = 4'h2,
        hst_mode_set = 4'h4,
        hst_idle = 4'h8
    } sdr_host_st_t;

endpackage

// ===== verification/sdr_cmd_bank_init_bench.sv
/* bench: controller and DRAM ends joined by sdr_if; assumes full pause */
`timescale 1ns/100ps
`include "sdr_params.svh"
module sdr_cmd_bank_init_bench;
    import sdr_pkg::*;
    typedef struct packed {
        logic w;
        logic [1:0] b;
        logic [11:0] r;
        logic [8:0] c;
        logic [15:0] d;
        logic [1:0] m;
    } sdr_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic sleep = 1'b0;
    logic req_ready, rsp_valid, init_done;
    logic [15:0] rsp_data;
    logic [11:0] mode_reg;
    logic [3:0] bank_open;
    sdr_pwr_t power_state;
    sdr_row_t req = '0;
    int err_total = 0;
    int compares = 0;
    int waited;
    // row 3 keeps the old low byte, row 4 floats the upper; row 5 misses
    sdr_row_t tbl [8] = '{
        '{1'b1, 2'h0, 12'h001, 9'h003, 16'h1234, 2'h0},
        '{1'b0, 2'h0, 12'h001, 9'h003, 16'h1234, 2'h0},
        '{1'b1, 2'h3, 12'hfff, 9'h1ff, 16'habcd, 2'h0},
        '{1'b1, 2'h0, 12'h001, 9'h003, 16'h5678, 2'h1},
        '{1'b0, 2'h3, 12'hfff, 9'h1ff, 16'h00cd, 2'h2},
        '{1'b1, 2'h0, 12'h003, 9'h003, 16'h9abc, 2'h0},
        '{1'b0, 2'h0, 12'h001, 9'h003, 16'h5634, 2'h0},
        '{1'b0, 2'h0, 12'h003, 9'h003, 16'h9abc, 2'h0}};
    sdr_if bus ();
    always #50 clk = ~clk;
    sdr_host_end i_sdr_host_end (.clk(clk), .rstn(rstn), .bus(bus.ctrl),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req.w),
        .req_bank(req.b), .req_row(req.r), .req_col(req.c),
        .req_wdata(req.d), .req_wmask(req.m), .sleep(sleep),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done));
    sdr_mem_end i_sdr_mem_end (.clk(clk), .rstn(rstn), .bus(bus.mem),
        .power_state(power_state), .mode_reg(mode_reg),
        .bank_open(bank_open));
    sdr_link_chk i_sdr_link_chk (.clk(clk), .rstn(rstn), .cs_n(bus.cs_n),
        .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
        .cke(bus.cke), .bank_select(bus.bank_select), .addr(bus.addr),
        .upper_lower_byte_mask(bus.upper_lower_byte_mask),
        .host_dq_oe(bus.host_dq_oe), .dev_dq_oe(bus.dev_dq_oe));
    task automatic summarize();
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    // 0 ready, 1 response, 2 clock enable low, 3 init done
    task automatic wait_until(input int sel);
        logic hit;
        for (waited = 0; waited < 3000; waited++) begin
            @(posedge clk);
            #1;
            hit = sel == 0 ? req_ready : sel == 1 ? rsp_valid :
                sel == 2 ? !bus.cke : init_done;
            if (hit === 1'b1) begin
                return;
            end
        end
        err_total++;
        summarize();
    endtask
    task automatic access(input sdr_row_t t);
        wait_until(0);
        req = t;
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        if (!t.w) begin
            wait_until(1);
            chk16(rsp_data, t.d);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'b1;
        wait_until(3);
        chk1(waited >= 1999, 1'b1);
        chk16({4'h0, mode_reg}, {4'h0, `SDR_MODE_VALUE});
        foreach (tbl[i]) access(tbl[i]);
        chk16({12'h000, bank_open}, 16'h0009);
        sleep = 1'b1;
        wait_until(2);
        repeat (2) @(posedge clk);
        #1;
        chk16({12'h000, power_state}, {12'h000, pwr_down});
        sleep = 1'b0;
        access(tbl[6]);
        rstn = 1'b0;
        #1;
        chk1(init_done, 1'b0);
        chk16({mode_reg, bank_open}, 16'h0000);
        @(posedge clk);
        #1;
        rstn = 1'b1;
        wait_until(3);
        // array has no reset, so data must survive
        access(tbl[7]);
        summarize();
    end
endmodule // sdr_cmd_bank_init_bench

// ===== verification/sdr_link_chk.sv
/* pin checker for sdr_if; assumes the bench wires it beside the link */
`timescale 1ns/100ps
`include "sdr_params.svh"
module sdr_link_chk (
    input logic clk,
    input logic rstn,
    input logic cs_n,
    input logic ras_n,
    input logic cas_n,
    input logic we_n,
    input logic cke,
    input logic [1:0] bank_select,
    input logic [`SDR_ADDR_W-1:0] addr,
    input logic [1:0] upper_lower_byte_mask,
    input logic host_dq_oe,
    input logic [1:0] dev_dq_oe
);
    import sdr_pkg::*;
    localparam int quiet_cyc = `SDR_INIT_PAUSE_CYC;
    sdr_cmd_t cmd;
    logic [11:0] age;
    logic [3:0] refs;
    logic [3:0] open;
    assign cmd = cs_n ? no_operation_cmd : sdr_cmd_t'({ras_n, cas_n, we_n});
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            age <= 12'h000;
        end else if (age != 12'hfff) begin
            age <= age + 12'h001;
        end
    end
    // self refresh entry is not an initial refresh
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refs <= 4'h0;
        end else if (cmd == cmd_auto_refresh && cke) begin
            refs <= refs + 4'h1;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            open <= 4'h0;
        end else if (cmd == cmd_activate) begin
            open[bank_select] <= 1'b1;
        end else if (cmd == cmd_precharge) begin
            open <= addr[`SDR_AP_BIT] ? 4'h0 : open & ~(4'h1 << bank_select);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_beat;
        ##2 dev_dq_oe == ~$past(upper_lower_byte_mask, 2);
    endsequence
    a_pause_quiet: assert property (
        age < quiet_cyc |-> cmd == no_operation_cmd && cke &&
        upper_lower_byte_mask == 2'h3) else $error("busy pause");
    a_mode_closed: assert property (
        cmd == cmd_mode_set |-> open == 4'h0 && $past(cke))
        else $error("mode set with bank open");
    a_mode_word: assert property (
        cmd == cmd_mode_set |-> addr == `SDR_MODE_VALUE)
        else $error("bad mode word");
    a_eight_refresh: assert property (
        cmd == cmd_activate |-> refs == 4'h8) else $error("refresh count");
    a_act_closed: assert property (
        cmd == cmd_activate |-> !open[bank_select])
        else $error("activate on open bank");
    a_col_open: assert property (
        cmd inside {cmd_read, cmd_write} |-> open[bank_select])
        else $error("access to closed bank");
    a_read_beat: assert property (
        cmd == cmd_read |-> s_beat) else $error("read beat late");
    a_beat_cause: assert property (
        dev_dq_oe != 2'h0 |-> $past(cmd, 2) == cmd_read)
        else $error("stray drive");
    a_write_data: assert property (
        cmd == cmd_write |-> host_dq_oe) else $error("write without data");
endmodule // sdr_link_chk
